// file: logic/sfl_defs.svh
// Constants for the synthesizer fast-lock control block
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH

// Control field of every serial word
`define SFL_CTL_MSB 2
`define SFL_CTL_LSB 0
`define SFL_SEL_FRACTION_NUMERATOR_INT 3'h0
`define SFL_SEL_PHASE 3'h1
`define SFL_SEL_MOD_REF 3'h2
`define SFL_SEL_FUNCTION 3'h3
`define SFL_SEL_CLK_DIV 3'h4

// Fraction/integer register
`define SFL_MUX_MSB 30
`define SFL_MUX_LSB 27
`define SFL_INT_MSB 26
`define SFL_INT_LSB 15
`define SFL_FRACTION_NUMERATOR_MSB 14
`define SFL_FRACTION_NUMERATOR_LSB 3
`define SFL_MUX_FAST_LOCK 4'hc

// Modulus/reference register
`define SFL_CSR_BIT 28
`define SFL_CP_MSB 27
`define SFL_CP_LSB 24
`define SFL_RDIV2_BIT 21
`define SFL_DOUBLER_BIT 20
`define SFL_RCNT_MSB 19
`define SFL_RCNT_LSB 15
`define SFL_MOD_MSB 14
`define SFL_MOD_LSB 3

// Function register
`define SFL_PD_POL_BIT 6

// Clock divider register
`define SFL_MODE_MSB 20
`define SFL_MODE_LSB 19
`define SFL_TMO_MSB 18
`define SFL_TMO_LSB 7
`define SFL_MODE_NONE 2'h0
`define SFL_MODE_FAST_LOCK 2'h1
`define SFL_MODE_RESYNC 2'h2

// Slip reduction cell limit and fast-lock pump current
`define SFL_CELLS_MAX 3'h7
`define SFL_CP_MAX 4'hf

// Host APB map (byte addresses)
`define SFL_A_CLK_DIV 12'h000
`define SFL_A_FUNCTION 12'h004
`define SFL_A_MOD_REF 12'h008
`define SFL_A_PHASE 12'h00c
`define SFL_A_FRACTION_NUMERATOR_INT 12'h010
`define SFL_A_GO 12'h014
`define SFL_A_STATUS 12'h018

// Status word
`define SFL_ST_BUSY 0
`define SFL_ST_DONE 1
`define SFL_ST_PFD_ERR 2
`define SFL_ST_CSR_MASK 3

// Go register commands
`define SFL_GO_INIT 0
`define SFL_GO_FREQ 1

// Comparison frequency ceiling
`define SFL_PFD_MAX_KHZ 32'h0000_7d00

`endif

// file: logic/sfl_pkg.sv
// Types shared by both ends of the synthesizer control link
package sfl_pkg;
    typedef enum logic [1:0] {
        SFL_IDLE,
        SFL_SEND,
        SFL_WAIT
    } sfl_host_state_t;

    typedef logic [31:0] sfl_word_t;
endpackage

// file: logic/sfl_link_if.sv
// Word link between the programming host and the synthesizer control
`timescale 1ns/1ps
interface sfl_link_if;
    logic [31:0] word;
    logic valid;
    logic ready;

    modport device (
        input word,
        input valid,
        output ready
    );

    modport host (
        output word,
        output valid,
        input ready
    );
endinterface

// file: logic/sfl_device.sv
// Synthesizer control end: registers, reference divider, slip reduction, fast lock
// Contract
// R1: Host loads clock-divider register first, fraction_numerator/int last
// R2: Division equals integer plus fraction over modulus
// R3: Comparison rate from doubler, counter, halving bit
// R4: Host keeps comparison rate at most 32 MHz
// R5: Halving uses toggle flop for even duty
// R6: Modulus twelve bits, reference counter five bits
// R7: Imminent slip enables one directed extra cell
// R8: Each further slip adds cell, seven max
// R9: After overshoot, cells turn off one by one
// R10: Slip reduction only when enable bit set
// R11: Host enables slip reduction only near 50% duty
// R12: Host never enables slip reduction with negative polarity
// R13: New frequency starts timer, boost, switch together
// R14: Wideband lasts for the programmed timeout
// R15: Timeout expiry restores current, opens switch
// R16: Host sets timeout near final settling
// R17: Mode field: 01 fast lock, 10 resync
// R18: Timeout field bits 18..7, counted in comparison cycles
// R19: Switch reaches mux pin only with select 1100
// R20: Cell count zero when disabled, never above seven
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_device
    import sfl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Link from the host
    sfl_link_if.device link,
    // Reference and loop observations
    input wire logic ref_in,
    input wire logic slip_imminent,
    input wire logic tune_up,
    input wire logic freq_passed,
    // Divider settings
    output logic [11:0] n_int,
    output logic [11:0] n_fraction_numerator,
    output logic [11:0] n_mod,
    // Comparison clock
    output logic pfd_clk,
    output logic pfd_tick,
    // Charge pump
    output logic [3:0] cp_current,
    output logic cp_boost,
    output logic [2:0] extra_cells,
    output logic extra_dir_up,
    // Multiplexed output pin
    output logic mux_o,
    output logic mux_oe
);

    sfl_word_t fraction_numerator_int_q;
    sfl_word_t mod_ref_q;
    sfl_word_t function_q;
    sfl_word_t phase_q;
    sfl_word_t clk_div_q;
    logic ref_q;
    logic ref_edge;
    logic [4:0] rcnt_q;
    logic rdone;
    logic half_q;
    logic tick_q;
    logic new_freq;
    logic [11:0] tmo_q;
    logic wide_q;
    logic [2:0] cells_q;
    logic dir_q;
    logic passed_q;
    logic csr_on;

    function automatic logic sel_is(input sfl_word_t w, input logic [2:0] sel);
        sel_is = (w[`SFL_CTL_MSB:`SFL_CTL_LSB] == sel);
    endfunction

    // Device always takes a word while enabled
    assign link.ready = ce;

    wire take = ce && link.valid;
    assign new_freq = take && sel_is(link.word, `SFL_SEL_FRACTION_NUMERATOR_INT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fraction_numerator_int_q <= 32'h0000_0000;
            mod_ref_q <= 32'h0000_0000;
            function_q <= 32'h0000_0000;
            phase_q <= 32'h0000_0000;
            clk_div_q <= 32'h0000_0000;
        end else if (take) begin
            // Each word lands in the register its control field names
            if (sel_is(link.word, `SFL_SEL_FRACTION_NUMERATOR_INT)) fraction_numerator_int_q <= link.word;
            if (sel_is(link.word, `SFL_SEL_PHASE)) phase_q <= link.word;
            if (sel_is(link.word, `SFL_SEL_MOD_REF)) mod_ref_q <= link.word;
            if (sel_is(link.word, `SFL_SEL_FUNCTION)) function_q <= link.word;
            if (sel_is(link.word, `SFL_SEL_CLK_DIV)) clk_div_q <= link.word;
        end
    end

    // N = INT + FRACTION_NUMERATOR/FRACTION_MODULUS is handed to the fractional divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_int <= 12'h000;
            n_fraction_numerator <= 12'h000;
            n_mod <= 12'h000;
            cp_current <= 4'h0;
        end else if (ce) begin
            n_int <= fraction_numerator_int_q[`SFL_INT_MSB:`SFL_INT_LSB]; // [R2]
            n_fraction_numerator <= fraction_numerator_int_q[`SFL_FRACTION_NUMERATOR_MSB:`SFL_FRACTION_NUMERATOR_LSB]; // [R2]
            n_mod <= mod_ref_q[`SFL_MOD_MSB:`SFL_MOD_LSB]; // [R6]
            cp_current <= cp_boost ? `SFL_CP_MAX : mod_ref_q[`SFL_CP_MSB:`SFL_CP_LSB];
        end
    end

    // Doubler counts both reference edges, otherwise the falling edge only
    assign ref_edge = mod_ref_q[`SFL_DOUBLER_BIT] ? (ref_in != ref_q) : (ref_q && !ref_in); // [R3]
    // Counter value 0 divides by 32
    // A count left above a newly loaded divider wraps at once, not after 32 edges
    assign rdone = ref_edge && (rcnt_q >= mod_ref_q[`SFL_RCNT_MSB:`SFL_RCNT_LSB] - 5'h01); // [R6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 1'b0;
            rcnt_q <= 5'h00;
        end else if (ce) begin
            ref_q <= ref_in;
            if (rdone) rcnt_q <= 5'h00;
            else if (ref_edge) rcnt_q <= rcnt_q + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (ce) begin
            if (rdone) half_q <= !half_q; // [R5]
            // Halving keeps every second counter pulse
            tick_q <= rdone && (!mod_ref_q[`SFL_RDIV2_BIT] || !half_q); // [R3]
        end
    end
    assign pfd_tick = tick_q;
    assign pfd_clk = mod_ref_q[`SFL_RDIV2_BIT] ? half_q : tick_q; // [R5]

    // Fast-lock wideband window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_q <= 1'b0;
            tmo_q <= 12'h000;
        end else if (ce) begin
            // A new frequency restarts the window even in mid-count
            if (new_freq && clk_div_q[`SFL_MODE_MSB:`SFL_MODE_LSB] == `SFL_MODE_FAST_LOCK) begin // [R17]
                wide_q <= 1'b1; // [R13]
                tmo_q <= clk_div_q[`SFL_TMO_MSB:`SFL_TMO_LSB]; // [R18] [R14]
            end else if (wide_q && tick_q) begin
                // Counts comparison cycles, so the window is value times t_pfd, and one t_pfd for value 0
                if (tmo_q <= 12'h001) begin
                    wide_q <= 1'b0; // [R15]
                    tmo_q <= 12'h000;
                end else begin
                    tmo_q <= tmo_q - 12'h001; // [R14]
                end
            end
        end
    end
    assign cp_boost = wide_q; // [R13] [R15]

    // Switch shorts the mux pin to ground while wideband, only with mux select 1100
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_o <= 1'b0;
            mux_oe <= 1'b0;
        end else if (ce) begin
            // Pin is only ever pulled low, never driven high
            mux_o <= 1'b0;
            mux_oe <= wide_q && (fraction_numerator_int_q[`SFL_MUX_MSB:`SFL_MUX_LSB] == `SFL_MUX_FAST_LOCK); // [R19]
        end
    end

    // Slip reduction cells
    assign csr_on = mod_ref_q[`SFL_CSR_BIT]; // [R10]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cells_q <= 3'h0;
            dir_q <= 1'b0;
            passed_q <= 1'b0;
        end else if (ce) begin
            if (!csr_on) begin
                cells_q <= 3'h0; // [R20]
                passed_q <= 1'b0;
            end else if (freq_passed || passed_q) begin
                // Overshoot wins over a slip in the same cycle
                passed_q <= (cells_q != 3'h0) || freq_passed;
                if (tick_q && cells_q != 3'h0) cells_q <= cells_q - 3'h1; // [R9]
                // A fresh overshoot in the same cycle keeps the release armed
                if (tick_q && cells_q <= 3'h1 && !freq_passed) passed_q <= 1'b0;
            end else if (slip_imminent) begin
                // Direction is latched at the first cell and held while any cell is on
                if (cells_q == 3'h0) dir_q <= tune_up; // [R7]
                if (cells_q != `SFL_CELLS_MAX) cells_q <= cells_q + 3'h1; // [R8] [R20]
            end
        end
    end
    assign extra_cells = cells_q; // [R7]
    assign extra_dir_up = dir_q;

endmodule // sfl_device

// file: logic/sfl_host.sv
// Programming host: APB staging registers and ordered word loads
`timescale 1ns/1ps
`include "sfl_defs.svh"
module sfl_host
    import sfl_pkg::*;
#(
    parameter logic [31:0] REF_IN_KHZ = 32'h0000_32c8
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the synthesizer
    sfl_link_if.host link
);

    sfl_word_t stage_q [0:4];
    sfl_host_state_t state_q;
    logic [2:0] idx_q;
    logic done_q;
    logic err_q;
    logic mask_q;
    sfl_word_t word_q;
    logic [31:0] num;
    logic [31:0] den;
    logic pfd_bad;
    logic csr_bad;

    wire acc = psel && penable && ce;
    wire wr = acc && pwrite;
    wire busy = (state_q != SFL_IDLE);

    // Comparison rate checked as REF*(1+D) > 32 MHz * R*(1+T)
    always_comb begin
        num = REF_IN_KHZ << stage_q[2][`SFL_DOUBLER_BIT];
        den = {27'h000_0000, stage_q[2][`SFL_RCNT_MSB:`SFL_RCNT_LSB]};
        if (den == 32'h0000_0000) den = 32'h0000_0020;
        den = 32'((64'(den) * 64'(`SFL_PFD_MAX_KHZ)) << stage_q[2][`SFL_RDIV2_BIT]);
        pfd_bad = num > den; // [R4]
    end
    // Even duty is only assured behind the halving flop
    assign csr_bad = !stage_q[2][`SFL_RDIV2_BIT] || !stage_q[1][`SFL_PD_POL_BIT]; // [R11] [R12]

    function automatic sfl_word_t fix(input sfl_word_t w, input logic [2:0] i);
        fix = w;
        fix[`SFL_CTL_MSB:`SFL_CTL_LSB] = `SFL_SEL_CLK_DIV - i; // [R1]
        if (i == 3'h2 && csr_bad) fix[`SFL_CSR_BIT] = 1'b0; // [R11] [R12]
    endfunction

    // Stage registers hold clock divider down to fraction_numerator/int, in load order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) stage_q[i] <= 32'h0000_0000;
        end else if (wr && !busy && paddr < `SFL_A_GO && paddr[1:0] == 2'h0) begin
            stage_q[paddr[4:2]] <= pwdata; // [R16]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SFL_IDLE;
            idx_q <= 3'h0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            mask_q <= 1'b0;
            word_q <= 32'h0000_0000;
        end else if (ce) begin
            case (state_q)
                SFL_IDLE: begin
                    if (wr && paddr == `SFL_A_GO && !pfd_bad) begin
                        err_q <= 1'b0;
                        done_q <= 1'b0;
                        mask_q <= csr_bad && stage_q[2][`SFL_CSR_BIT];
                        if (pwdata[`SFL_GO_INIT]) begin
                            idx_q <= 3'h0; // [R1]
                            word_q <= fix(stage_q[0], 3'h0);
                            state_q <= SFL_SEND;
                        end else if (pwdata[`SFL_GO_FREQ]) begin
                            idx_q <= 3'h4;
                            word_q <= fix(stage_q[4], 3'h4);
                            state_q <= SFL_SEND;
                        end
                    end else if (wr && paddr == `SFL_A_GO) begin
                        err_q <= 1'b1; // [R4]
                    end
                end
                SFL_SEND: begin
                    if (link.ready) begin
                        if (idx_q == 3'h4) begin
                            state_q <= SFL_WAIT;
                        end else begin
                            idx_q <= idx_q + 3'h1; // [R1]
                            word_q <= fix(stage_q[idx_q + 3'h1], idx_q + 3'h1);
                        end
                    end
                end
                SFL_WAIT: begin
                    done_q <= 1'b1;
                    state_q <= SFL_IDLE;
                end
                default: state_q <= SFL_IDLE;
            endcase
        end
    end
    assign link.valid = (state_q == SFL_SEND);
    assign link.word = word_q;

    // Zero-wait slave, read data registered at the edge that ends the setup phase
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            if (paddr < `SFL_A_GO && paddr[1:0] == 2'h0) prdata <= stage_q[paddr[4:2]];
            else if (paddr == `SFL_A_STATUS)
                prdata <= {28'h000_0000, mask_q, err_q, done_q, busy};
            else prdata <= 32'h0000_0000;
        end
    end

endmodule // sfl_host

// file: dv/sfl_asserts.sv
// Checker for the control link and the loop outputs of the synthesizer end
`timescale 1ns/1ps
module sfl_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Link
    input wire logic [31:0] word,
    input wire logic valid,
    input wire logic ready,
    // Loop side
    input wire logic slip_imminent,
    input wire logic freq_passed,
    input wire logic pfd_tick,
    input wire logic [3:0] cp_current,
    input wire logic cp_boost,
    input wire logic [2:0] extra_cells,
    input wire logic [11:0] n_int,
    input wire logic [11:0] n_mod,
    input wire logic mux_o,
    input wire logic mux_oe
);
    logic tk;
    logic csr_q;
    logic [1:0] mode_q;
    logic [3:0] cp_q;
    logic [3:0] sel_q;

    assign tk = valid && ready;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of what the device was last loaded with
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_q <= 1'b0;
            mode_q <= 2'h0;
            cp_q <= 4'h0;
            sel_q <= 4'h0;
        end else if (tk && word[2:0] == 3'h2) begin
            csr_q <= word[28];
            cp_q <= word[27:24];
        end else if (tk && word[2:0] == 3'h4) begin
            mode_q <= word[20:19];
        end else if (tk && word[2:0] == 3'h0) begin
            sel_q <= word[30:27];
        end
    end

    AST_LOAD_INT: assert property (tk && word[2:0] == 3'h0
        |=> ##1 n_int == $past(word[26:15], 2))
        else $error("integer setting not loaded");
    AST_LOAD_MOD: assert property (tk && word[2:0] == 3'h2
        |=> ##1 n_mod == $past(word[14:3], 2))
        else $error("modulus not loaded");
    AST_ORDER: assert property (tk && word[2:0] == 3'h4 |=> valid && word[2:0] == 3'h3)
        else $error("function word does not follow clock divider word");
    AST_CSR_OFF: assert property (tk && word[2:0] == 3'h2 && !word[28] |=> extra_cells == 3'h0)
        else $error("extra cells left on with slip reduction off");
    AST_CELL_UP: assert property (csr_q && ce && slip_imminent && !freq_passed && !tk
        && extra_cells != 3'h7 |=> extra_cells == $past(extra_cells) + 3'h1)
        else $error("extra cell not added");
    AST_CELL_SAT: assert property (extra_cells == 3'h7 && slip_imminent && !freq_passed
        |=> extra_cells == 3'h7)
        else $error("extra cell count left its maximum");
    AST_CELL_DOWN: assert property ((extra_cells < $past(extra_cells)) && csr_q && $past(csr_q)
        |-> extra_cells == $past(extra_cells) - 3'h1 && $past(pfd_tick))
        else $error("extra cells not released one per comparison cycle");
    AST_BOOST_GO: assert property (tk && word[2:0] == 3'h0 && mode_q == 2'h1 |=> cp_boost)
        else $error("new frequency did not start wideband");
    AST_NO_BOOST: assert property (tk && word[2:0] == 3'h0 && mode_q != 2'h1 && !cp_boost
        |=> !cp_boost)
        else $error("wideband started outside fast lock mode");
    AST_BOOST_END: assert property ($fell(cp_boost) |-> $past(pfd_tick))
        else $error("wideband ended between comparison cycles");
    AST_CP_BACK: assert property ($fell(cp_boost) |=> cp_current == cp_q)
        else $error("pump current not restored after wideband");
    AST_CP_MAX: assert property (cp_boost && $past(cp_boost) |-> cp_current == 4'hf)
        else $error("pump current not at maximum in wideband");
    AST_MUX: assert property (mux_oe |-> !mux_o && sel_q == 4'hc)
        else $error("fast lock switch on pin without its select code");
endmodule // sfl_asserts

// file: dv/testbench.sv
// Testbench: APB programming of the host, linked device, loop stimulus
`timescale 1ns/1ps
`include "sfl_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, ref_in = 1'b0, slip = 1'b0, tune_up = 1'b0, fpass = 1'b0;
    logic [11:0] n_int, n_fraction_numerator, n_mod;
    logic pfd_clk, pfd_tick, cp_boost, extra_dir_up, mux_o, mux_oe, win = 1'b0, ms, chi;
    logic [3:0] cp_current;
    logic [2:0] extra_cells, rc = 3'h0;
    int fail_count = 0, checks_done = 0, cyc = 0, nt, nh, bt;
    logic [1:0] md [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
    logic [11:0] tm [4] = '{12'h005, 12'h003, 12'h003, 12'h000};
    logic [3:0] sl [4] = '{4'hc, 4'hc, 4'hc, 4'h0};
    int eb [4] = '{5, 0, 0, 1};
    logic [4:0] rt [3] = '{5'h01, 5'h02, 5'h04};
    logic dt [3] = '{1'b0, 1'b1, 1'b0};
    int et [3] = '{20, 20, 5};

    sfl_link_if sfl_link_if_i ();
    // Reference rate raised so that doubling with no division overruns the ceiling
    sfl_host #(.REF_IN_KHZ(32'h0000_4e20)) sfl_host_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(sfl_link_if_i));
    sfl_device sfl_device_i (.pclk(pclk), .presetn(presetn), .ce(ce), .link(sfl_link_if_i),
        .ref_in(ref_in), .slip_imminent(slip), .tune_up(tune_up), .freq_passed(fpass),
        .n_int(n_int), .n_fraction_numerator(n_fraction_numerator), .n_mod(n_mod), .pfd_clk(pfd_clk), .pfd_tick(pfd_tick),
        .cp_current(cp_current), .cp_boost(cp_boost), .extra_cells(extra_cells),
        .extra_dir_up(extra_dir_up), .mux_o(mux_o), .mux_oe(mux_oe));
    sfl_asserts sfl_asserts_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .word(sfl_link_if_i.word), .valid(sfl_link_if_i.valid), .ready(sfl_link_if_i.ready),
        .slip_imminent(slip), .freq_passed(fpass), .pfd_tick(pfd_tick),
        .cp_current(cp_current), .cp_boost(cp_boost), .extra_cells(extra_cells),
        .n_int(n_int), .n_mod(n_mod), .mux_o(mux_o), .mux_oe(mux_oe));

    initial begin
        forever #25 pclk = ~pclk;
    end

    // Reference toggles every four cycles; monitors sample before each edge lands
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rc <= rc + 3'h1;
        if (rc[1:0] == 2'h3) ref_in <= ~ref_in;
        if (win) begin
            nt <= nt + pfd_tick;
            nh <= nh + pfd_clk;
        end
        if (cp_boost && pfd_tick) bt <= bt + 1;
        if (mux_oe) ms <= 1'b1;
        if (cp_current == 4'hf) chi <= 1'b1;
        if (cyc == 60000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] mr(input logic cycle_slip_reduction, input logic h, input logic d,
        input logic [4:0] r);
        return {3'h0, cycle_slip_reduction, 4'h5, 2'h0, h, d, r, 12'h041, 3'h0};
    endfunction

    function automatic logic [31:0] cd(input logic [1:0] m, input logic [11:0] t);
        return {11'h000, m, t, 7'h00};
    endfunction

    task automatic cfg(input logic [31:0] c, input logic [31:0] f, input logic [31:0] m,
        input logic [3:0] s, input logic [31:0] go);
        apb(1'b1, `SFL_A_CLK_DIV, c);
        apb(1'b1, `SFL_A_FUNCTION, f);
        apb(1'b1, `SFL_A_MOD_REF, m);
        apb(1'b1, `SFL_A_PHASE, 32'h0000_0008);
        apb(1'b1, `SFL_A_FRACTION_NUMERATOR_INT, {1'b0, s, 12'h08a, 12'h01e, 3'h0});
        apb(1'b1, `SFL_A_GO, go);
        rd = 32'h0000_0000;
        for (int i = 0; i < 50 && rd[`SFL_ST_DONE] !== 1'b1; i++) apb(1'b0, `SFL_A_STATUS, 0);
    endtask

    task automatic meas();
        @(posedge pclk);
        nt <= 0;
        nh <= 0;
        win <= 1'b1;
        repeat (160) @(posedge pclk);
        win <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_boost();
        for (int k = 0; k < 400 && cp_boost !== 1'b0; k++) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SFL_A_STATUS, 0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, 12'h040, 32'hffff_ffff);
        apb(1'b0, 12'h040, 0);
        `CHK(rd, 32'h0000_0000)
        for (int i = 0; i < 3; i++) begin
            cfg(cd(2'h0, 12'h000), 32'h0000_0040, mr(1'b0, 1'b0, dt[i], rt[i]), 4'h0, 32'h1);
            meas();
            `CHK(nt, et[i])
            `CHK(nh, et[i])
            `CHK(n_mod, 12'h041)
            `CHK({n_int, n_fraction_numerator}, {12'h08a, 12'h01e})
        end
        cfg(cd(2'h0, 12'h000), 32'h0000_0040, mr(1'b0, 1'b0, 1'b1, 5'h01), 4'h0, 32'h1);
        apb(1'b0, `SFL_A_STATUS, 0);
        `CHK(rd[`SFL_ST_PFD_ERR], 1'b1)
        for (int i = 0; i < 4; i++) begin
            bt <= 0;
            ms <= 1'b0;
            chi <= 1'b0;
            cfg(cd(md[i], tm[i]), 32'h0000_0040, mr(1'b0, 1'b0, 1'b0, 5'h01), sl[i], 32'h1);
            wait_boost();
            `CHK(bt, eb[i])
            `CHK(ms, (eb[i] != 0 && sl[i] == 4'hc))
            `CHK(chi, (eb[i] != 0))
            `CHK(cp_current, 4'h5)
        end
        // Clock enable low must stall the new frequency word
        bt <= 0;
        apb(1'b1, `SFL_A_GO, 32'h2);
        ce <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK(cp_boost, 1'b0)
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(cp_boost, 1'b1)
        wait_boost();
        `CHK(bt, 1)
        tune_up <= 1'b1;
        cfg(cd(2'h0, 12'h000), 32'h0000_0040, mr(1'b1, 1'b1, 1'b0, 5'h01), 4'h0, 32'h1);
        apb(1'b0, `SFL_A_STATUS, 0);
        `CHK(rd[`SFL_ST_CSR_MASK], 1'b0)
        meas();
        `CHK(nh, 80)
        slip <= 1'b1;
        @(posedge pclk);
        slip <= 1'b0;
        @(posedge pclk);
        `CHK({extra_cells, extra_dir_up}, {3'h1, 1'b1})
        slip <= 1'b1;
        repeat (9) @(posedge pclk);
        slip <= 1'b0;
        @(posedge pclk);
        `CHK(extra_cells, 3'h7)
        fpass <= 1'b1;
        @(posedge pclk);
        fpass <= 1'b0;
        for (int k = 0; k < 200 && extra_cells !== 3'h0; k++) @(posedge pclk);
        `CHK(extra_cells, 3'h0)
        for (int j = 0; j < 2; j++) begin
            cfg(cd(2'h0, 12'h000), j ? 32'h0 : 32'h40, mr(1'b1, j[0], 1'b0, 5'h01), 4'h0, 32'h1);
            apb(1'b0, `SFL_A_STATUS, 0);
            `CHK(rd[`SFL_ST_CSR_MASK], 1'b1)
            slip <= 1'b1;
            repeat (3) @(posedge pclk);
            slip <= 1'b0;
            @(posedge pclk);
            `CHK(extra_cells, 3'h0)
        end
        test_done();
    end
endmodule // testbench
